// ---- logic/serial_pins_pkg.sv ----
package serial_pins_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int PIN_W = 7;
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;

  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [7:0] GOPT24_IDX = 8'h24;
  localparam logic [7:0] GOPT26_IDX = 8'h26;
  localparam logic [7:0] GPIO6_DIR_IDX = 8'h28;
  localparam logic [7:0] GPIO6_DATA_IDX = 8'h29;
  localparam logic [7:0] GPIO6_PIN_IDX = 8'h2a;
  localparam logic [7:0] PORT_STAT_IDX = 8'h2b;
  localparam logic [7:0] STRAP_IDX = 8'h2c;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int KBD_EN_BIT = 2;
  localparam int ROM_EN_BIT = 1;
  localparam int CFG_ADDR_BIT = 6;
  localparam int PIN_RING = 0;
  localparam int PIN_DCD = 1;
  localparam int PIN_TX = 2;
  localparam int PIN_RX = 3;
  localparam int PIN_DTR = 4;
  localparam int PIN_RTS = 5;
  localparam int PIN_DSR = 6;
  localparam int STAT_DONE_BIT = 7;

  // ****************************************
  // Masks and values after reset
  // ****************************************
  localparam logic [PIN_W-1:0] SER_OUT_MASK = 7'h34;
  localparam logic [PIN_W-1:0] GPIO_OD_MASK = 7'h4b;
  localparam logic [7:0] GOPT24_RST = 8'h00;
  localparam logic [7:0] GOPT26_RST = 8'h00;
  localparam logic [PIN_W-1:0] GPIO6_DIR_RST = 7'h00;
  localparam logic [PIN_W-1:0] GPIO6_DATA_RST = 7'h7f;
  localparam logic [PIN_W-1:0] SYNC_RST = 7'h00;
  localparam logic [7:0] CFG_ADDR_LOW = 8'h2e;
  localparam logic [7:0] CFG_ADDR_HIGH = 8'h4e;

  // ****************************************
  // Counts
  // ****************************************
  localparam logic [2:0] STRAP_SETTLE = 3'h4;

  // ****************************************
  // Strap phase
  // ****************************************
  typedef enum logic [1:0] {
    PH_HOLD = 2'b00,
    PH_SETTLE = 2'b01,
    PH_RUN = 2'b10
  } strap_phase_t;

endpackage

// ---- logic/pin_mux_if.sv ----
interface pin_mux_if
  import serial_pins_pkg::*;
;
  logic pinsFree;
  logic [PIN_W-1:0] gpioSel;
  logic [PIN_W-1:0] serOut;
  logic [PIN_W-1:0] serOe;
  logic [PIN_W-1:0] gpioOut;
  logic [PIN_W-1:0] gpioOe;
  logic [PIN_W-1:0] pinOut;
  logic [PIN_W-1:0] pinOe;

  modport ctrl (
    output pinsFree, gpioSel, serOut, serOe, gpioOut, gpioOe,
    input pinOut, pinOe
  );
  modport mux (
    input pinsFree, gpioSel, serOut, serOe, gpioOut, gpioOe,
    output pinOut, pinOe
  );
endinterface

// ---- logic/sync_filter.sv ----
module sync_filter
  import serial_pins_pkg::*;
(
  // Clock, enable and reset
  input wire logic clk,
  input wire logic ce,
  input wire logic reset_n,
  // Pins in, filtered levels out
  input wire logic [PIN_W-1:0] din,
  output logic [PIN_W-1:0] dout
);

  logic [PIN_W-1:0] s1_r;
  logic [PIN_W-1:0] s2_r;
  logic [PIN_W-1:0] s3_r;

  // ****************************************
  // Three stages, change taken when 2 and 3 agree
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= SYNC_RST;
      s2_r <= SYNC_RST;
      s3_r <= SYNC_RST;
    end else if (ce) begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  genvar i;
  generate
    for (i = 0; i < PIN_W; i++) begin : gBit
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          dout[i] <= SYNC_RST[i];
        end else if (ce && (s2_r[i] == s3_r[i])) begin
          dout[i] <= s3_r[i];
        end
      end
    end
  endgenerate

endmodule

// ---- logic/pin_mux.sv ----
module pin_mux
  import serial_pins_pkg::*;
(
  // Clock, enable and reset
  input wire logic clk,
  input wire logic ce,
  input wire logic reset_n,
  // Selection and drive
  pin_mux_if.mux mx
);

  genvar i;
  generate
    for (i = 0; i < PIN_W; i++) begin : gPin
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          mx.pinOut[i] <= 1'b0;
          mx.pinOe[i] <= 1'b0;
        end else if (ce) begin
          if (!mx.pinsFree) begin
            mx.pinOut[i] <= 1'b0;
            mx.pinOe[i] <= 1'b0;
          end else if (mx.gpioSel[i]) begin
            mx.pinOut[i] <= mx.gpioOut[i];
            mx.pinOe[i] <= mx.gpioOe[i];
          end else begin
            mx.pinOut[i] <= mx.serOut[i];
            mx.pinOe[i] <= mx.serOe[i];
          end
        end
      end
    end
  endgenerate

endmodule

// ---- logic/serial_port_a_pins.sv ----
// What this block does
// - Low ring pin reports an incoming ring from the modem
// - Low carrier pin reports a detected data carrier
// - Transmit data from the serial core drives the transmit pin
// - Receive pin feeds incoming serial data to the serial core
// - Terminal-ready pin driven low tells the modem we can talk
// - Request-to-send pin driven low tells the modem we can send
// - Keyboard strap sampled at power-on, shown in option reg 24 bit 2
// - Low keyboard strap leaves keyboard controller off, high enables it
// - ROM strap sampled at power-on into option reg 24 bit 1
// - Low ROM strap leaves flash interface off, high enables it
// - Address strap sampled at power-on into option reg 26 bit 6
// - Address strap low selects 2e, high selects 4e
// - Each modem pin doubles as general-purpose port 6 bits 0 to 6
//
// The address map and the APB interface to the registers were chosen for this implementation.
module serial_port_a_pins
  import serial_pins_pkg::*;
(
  // Clock, enable and reset
  input wire logic clk,
  input wire logic ce,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  output logic [APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Shared modem pins, index 0 ring .. 6 set ready
  input wire logic [PIN_W-1:0] modemPinIn,
  output logic [PIN_W-1:0] modemPinOut,
  output logic [PIN_W-1:0] modemPinOe,
  // Function choice per pin, 1 selects general-purpose
  input wire logic [PIN_W-1:0] pinFuncGpio,
  // Serial core side
  input wire logic portASerialTx,
  input wire logic portATerminalReadyN,
  input wire logic portARequestSendN,
  output logic portASerialRx,
  output logic portARingInN,
  output logic portACarrierDetectN,
  output logic portASetReadyN,
  // Configuration results
  output logic kbdCtrlEnable,
  output logic romIfEnable,
  output logic [7:0] cfgPortAddr,
  output logic strapsDone
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [PIN_W-1:0] pinLevel;
  strap_phase_t phase_r;
  strap_phase_t phase_nxt;
  logic [2:0] settleCnt_r;
  logic strapTake;
  logic kbdStrap_r;
  logic romStrap_r;
  logic cfgStrap_r;
  logic [7:0] gopt24_r;
  logic [7:0] gopt26_r;
  logic [PIN_W-1:0] gpioDir_r;
  logic [PIN_W-1:0] gpioData_r;
  logic [APB_DW-1:0] prdata_r;
  logic [7:0] cfgPortAddr_r;
  logic portASerialRx_r;
  logic ringInN_r;
  logic carrierN_r;
  logic setReadyN_r;
  logic setupPh;
  logic accessPh;
  logic wrEn;
  logic mapped;
  logic [APB_DW-1:0] rdMux;
  logic [PIN_W-1:0] serOutVec;

  pin_mux_if pmx ();

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic regHit(input logic [APB_AW-1:0] a,
                                  input logic [7:0] idx);
    regHit = (a[1:0] == 2'h0) && (a[APB_AW-1:2] == {2'h0, idx});
  endfunction

  // ****************************************
  // Pin input synchroniser
  // ****************************************
  sync_filter uSync (
    .clk(clk),
    .ce(ce),
    .reset_n(reset_n),
    .din(modemPinIn),
    .dout(pinLevel)
  );

  // ****************************************
  // Strap phase
  // ****************************************
  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      PH_HOLD: begin
        phase_nxt = PH_SETTLE;
      end
      PH_SETTLE: begin
        if (settleCnt_r == STRAP_SETTLE - 3'h1) begin
          phase_nxt = PH_RUN;
        end
      end
      PH_RUN: begin
        phase_nxt = PH_RUN;
      end
      default: begin
        phase_nxt = PH_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_r <= PH_HOLD;
    end else if (ce) begin
      phase_r <= phase_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settleCnt_r <= 3'h0;
    end else if (ce && phase_r == PH_SETTLE) begin
      settleCnt_r <= settleCnt_r + 3'h1;
    end
  end

  assign strapTake = ce && (phase_r == PH_SETTLE) &&
                     (settleCnt_r == STRAP_SETTLE - 3'h1);
  assign strapsDone = (phase_r == PH_RUN);

  // ****************************************
  // Strap capture, once only
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      kbdStrap_r <= 1'b0;
      romStrap_r <= 1'b0;
      cfgStrap_r <= 1'b0;
    end else if (strapTake) begin
      kbdStrap_r <= pinLevel[PIN_TX];
      romStrap_r <= pinLevel[PIN_DTR];
      cfgStrap_r <= pinLevel[PIN_RTS];
    end
  end

  // ****************************************
  // APB handshake
  // ****************************************
  assign setupPh = psel && !penable;
  assign accessPh = psel && penable;
  assign wrEn = accessPh && pwrite && ce;
  assign pready = ce;
  assign mapped = regHit(paddr, GOPT24_IDX) ||
                  regHit(paddr, GOPT26_IDX) ||
                  regHit(paddr, GPIO6_DIR_IDX) ||
                  regHit(paddr, GPIO6_DATA_IDX) ||
                  regHit(paddr, GPIO6_PIN_IDX) ||
                  regHit(paddr, PORT_STAT_IDX) ||
                  regHit(paddr, STRAP_IDX);
  assign pslverr = accessPh && !mapped;

  // ****************************************
  // Option register 24
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gopt24_r <= GOPT24_RST;
    end else if (strapTake) begin
      gopt24_r[KBD_EN_BIT] <= pinLevel[PIN_TX];
      gopt24_r[ROM_EN_BIT] <= pinLevel[PIN_DTR];
    end else if (wrEn && regHit(paddr, GOPT24_IDX)) begin
      gopt24_r[KBD_EN_BIT] <= pwdata[KBD_EN_BIT];
      gopt24_r[ROM_EN_BIT] <= pwdata[ROM_EN_BIT];
    end
  end

  // ****************************************
  // Option register 26
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gopt26_r <= GOPT26_RST;
    end else if (strapTake) begin
      gopt26_r[CFG_ADDR_BIT] <= pinLevel[PIN_RTS];
    end else if (wrEn && regHit(paddr, GOPT26_IDX)) begin
      gopt26_r[CFG_ADDR_BIT] <= pwdata[CFG_ADDR_BIT];
    end
  end

  // ****************************************
  // Configuration results
  // ****************************************
  assign kbdCtrlEnable = gopt24_r[KBD_EN_BIT];
  assign romIfEnable = gopt24_r[ROM_EN_BIT];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfgPortAddr_r <= CFG_ADDR_LOW;
    end else if (ce) begin
      cfgPortAddr_r <= gopt26_r[CFG_ADDR_BIT] ? CFG_ADDR_HIGH
                                              : CFG_ADDR_LOW;
    end
  end
  assign cfgPortAddr = cfgPortAddr_r;

  // ****************************************
  // General-purpose port 6
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gpioDir_r <= GPIO6_DIR_RST;
    end else if (wrEn && regHit(paddr, GPIO6_DIR_IDX)) begin
      gpioDir_r <= pwdata[PIN_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gpioData_r <= GPIO6_DATA_RST;
    end else if (wrEn && regHit(paddr, GPIO6_DATA_IDX)) begin
      gpioData_r <= pwdata[PIN_W-1:0];
    end
  end

  // ****************************************
  // Pin function mux
  // ****************************************
  always_comb begin
    serOutVec = '0;
    serOutVec[PIN_TX] = portASerialTx;
    serOutVec[PIN_DTR] = portATerminalReadyN;
    serOutVec[PIN_RTS] = portARequestSendN;
  end

  assign pmx.pinsFree = strapsDone;
  assign pmx.gpioSel = pinFuncGpio;
  assign pmx.serOut = serOutVec;
  assign pmx.serOe = SER_OUT_MASK;
  assign pmx.gpioOut = gpioData_r & ~GPIO_OD_MASK;
  assign pmx.gpioOe = gpioDir_r & (~GPIO_OD_MASK | ~gpioData_r);

  pin_mux uMux (
    .clk(clk),
    .ce(ce),
    .reset_n(reset_n),
    .mx(pmx.mux)
  );

  assign modemPinOut = pmx.pinOut;
  assign modemPinOe = pmx.pinOe;

  // ****************************************
  // Modem inputs to serial core
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      portASerialRx_r <= 1'b1;
      ringInN_r <= 1'b1;
      carrierN_r <= 1'b1;
      setReadyN_r <= 1'b1;
    end else if (ce) begin
      portASerialRx_r <= pinFuncGpio[PIN_RX] | pinLevel[PIN_RX];
      ringInN_r <= pinFuncGpio[PIN_RING] | pinLevel[PIN_RING];
      carrierN_r <= pinFuncGpio[PIN_DCD] | pinLevel[PIN_DCD];
      setReadyN_r <= pinFuncGpio[PIN_DSR] | pinLevel[PIN_DSR];
    end
  end

  assign portASerialRx = portASerialRx_r;
  assign portARingInN = ringInN_r;
  assign portACarrierDetectN = carrierN_r;
  assign portASetReadyN = setReadyN_r;

  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    rdMux = '0;
    if (regHit(paddr, GOPT24_IDX)) begin
      rdMux[7:0] = gopt24_r;
    end else if (regHit(paddr, GOPT26_IDX)) begin
      rdMux[7:0] = gopt26_r;
    end else if (regHit(paddr, GPIO6_DIR_IDX)) begin
      rdMux[PIN_W-1:0] = gpioDir_r;
    end else if (regHit(paddr, GPIO6_DATA_IDX)) begin
      rdMux[PIN_W-1:0] = gpioData_r;
    end else if (regHit(paddr, GPIO6_PIN_IDX)) begin
      rdMux[PIN_W-1:0] = pinLevel;
    end else if (regHit(paddr, PORT_STAT_IDX)) begin
      rdMux[PIN_RING] = ~ringInN_r;
      rdMux[PIN_DCD] = ~carrierN_r;
      rdMux[PIN_RX] = portASerialRx_r;
      rdMux[PIN_DSR] = ~setReadyN_r;
      rdMux[STAT_DONE_BIT] = strapsDone;
    end else if (regHit(paddr, STRAP_IDX)) begin
      rdMux[KBD_EN_BIT] = kbdStrap_r;
      rdMux[ROM_EN_BIT] = romStrap_r;
      rdMux[CFG_ADDR_BIT] = cfgStrap_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata_r <= '0;
    end else if (ce && setupPh) begin
      prdata_r <= rdMux;
    end
  end
  assign prdata = prdata_r;

endmodule

// ---- dv/serial_pins_chk.sv ----
module serial_pins_chk
  import serial_pins_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Pins and function choice
  input wire logic [PIN_W-1:0] modemPinIn,
  input wire logic [PIN_W-1:0] modemPinOut,
  input wire logic [PIN_W-1:0] modemPinOe,
  input wire logic [PIN_W-1:0] pinFuncGpio,
  // Serial core side
  input wire logic portASerialTx,
  input wire logic portATerminalReadyN,
  input wire logic portARequestSendN,
  input wire logic portASerialRx,
  input wire logic portARingInN,
  input wire logic portACarrierDetectN,
  // Configuration results
  input wire logic kbdCtrlEnable,
  input wire logic romIfEnable,
  input wire logic [7:0] cfgPortAddr,
  input wire logic strapsDone
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  oe_hold_a: assert property (
    !strapsDone |-> modemPinOe == 7'h00) else $error("Pin driven early");
  tx_drive_a: assert property (
    $past(strapsDone) && !$past(pinFuncGpio[2]) |->
    modemPinOe[2] && modemPinOut[2] == $past(portASerialTx))
    else $error("Transmit pin wrong");
  dtr_drive_a: assert property (
    $past(strapsDone) && !$past(pinFuncGpio[4]) |->
    modemPinOe[4] && modemPinOut[4] == $past(portATerminalReadyN))
    else $error("Terminal ready pin wrong");
  rts_drive_a: assert property (
    $past(strapsDone) && !$past(pinFuncGpio[5]) |->
    modemPinOe[5] && modemPinOut[5] == $past(portARequestSendN))
    else $error("Request send pin wrong");
  rx_follow_a: assert property (
    (strapsDone && !pinFuncGpio[3] && $stable(modemPinIn[3])) [*6] |->
    portASerialRx == modemPinIn[3]) else $error("Receive path wrong");
  ring_follow_a: assert property (
    (strapsDone && !pinFuncGpio[0] && $stable(modemPinIn[0])) [*6] |->
    portARingInN == modemPinIn[0]) else $error("Ring path wrong");
  carrier_follow_a: assert property (
    (strapsDone && !pinFuncGpio[1] && $stable(modemPinIn[1])) [*6] |->
    portACarrierDetectN == modemPinIn[1]) else $error("Carrier path wrong");
  gpio_mask_a: assert property (
    pinFuncGpio[0] [*2] |-> portARingInN) else $error("Ring not masked");
  kbd_strap_a: assert property (
    $rose(strapsDone) |-> kbdCtrlEnable == $past(modemPinIn[2]))
    else $error("Keyboard strap wrong");
  rom_strap_a: assert property (
    $rose(strapsDone) |-> romIfEnable == $past(modemPinIn[4]))
    else $error("Flash strap wrong");
  cfg_strap_a: assert property (
    $rose(strapsDone) |-> ##1
    cfgPortAddr == ($past(modemPinIn[5], 2) ? 8'h4e : 8'h2e))
    else $error("Config address strap wrong");
endmodule

bind serial_port_a_pins serial_pins_chk i_chk (.clk, .reset_n, .modemPinIn,
  .modemPinOut, .modemPinOe, .pinFuncGpio, .portASerialTx,
  .portATerminalReadyN, .portARequestSendN, .portASerialRx, .portARingInN,
  .portACarrierDetectN, .kbdCtrlEnable, .romIfEnable, .cfgPortAddr,
  .strapsDone);

// ---- dv/modem_model.sv ----
module modem_model
  import serial_pins_pkg::*;
(
  // Strap levels, released once taken
  input wire logic [2:0] strapVal,
  input wire logic strapsDone,
  // Modem lines: set ready, rx, carrier, ring
  input wire logic [3:0] modemCtl,
  // Device drive and resolved pin levels
  input wire logic [PIN_W-1:0] modemPinOut,
  input wire logic [PIN_W-1:0] modemPinOe,
  output logic [PIN_W-1:0] modemPinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PIN_W-1:0] far;

  // Released strap pins fall to their pull-downs
  assign far[0] = modemCtl[0];
  assign far[1] = modemCtl[1];
  assign far[2] = strapVal[0] & ~strapsDone;
  assign far[3] = modemCtl[2];
  assign far[4] = strapVal[1] & ~strapsDone;
  assign far[5] = strapVal[2] & ~strapsDone;
  assign far[6] = modemCtl[3];
  // Open-drain pins only pull low
  assign modemPinIn = (modemPinOe & modemPinOut & (far | ~GPIO_OD_MASK))
    | (~modemPinOe & far);
endmodule

// ---- dv/tb_top.sv ----
module tb_top
  import serial_pins_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, ce, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata;
  logic [PIN_W-1:0] modemPinIn, modemPinOut, modemPinOe, pinFuncGpio;
  logic portASerialTx, portATerminalReadyN, portARequestSendN;
  logic portASerialRx, portARingInN, portACarrierDetectN, portASetReadyN;
  logic kbdCtrlEnable, romIfEnable, strapsDone;
  logic [7:0] cfgPortAddr;
  logic [2:0] strapVal;
  logic [3:0] modemCtl;
  int miscompares, samples_checked;

  serial_port_a_pins i_dut (.clk, .ce, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .modemPinIn, .modemPinOut,
    .modemPinOe, .pinFuncGpio, .portASerialTx, .portATerminalReadyN,
    .portARequestSendN, .portASerialRx, .portARingInN, .portACarrierDetectN,
    .portASetReadyN, .kbdCtrlEnable, .romIfEnable, .cfgPortAddr,
    .strapsDone);
  modem_model i_modem (.strapVal, .strapsDone, .modemCtl, .modemPinOut,
    .modemPinOe, .modemPinIn);

  always #20 clk = ~clk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, idx, d, q, e);
  endtask

  task automatic rdChk(input string nm, input logic [7:0] idx,
                       input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, idx, 32'h0, q, e);
    chk(nm, q, x);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic tStraps(input logic [2:0] s);
    int n;
    @(posedge clk);
    reset_n <= 1'b0;
    strapVal <= s;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    n = 0;
    while (strapsDone !== 1'b1 && n < 100) begin
      settle(1);
      n++;
    end
    settle(1);
    chk("strapsDone", 32'(strapsDone), 32'h1);
    chk("kbdEnable", 32'(kbdCtrlEnable), 32'(s[0]));
    chk("romEnable", 32'(romIfEnable), 32'(s[1]));
    chk("cfgAddr", 32'(cfgPortAddr), s[2] ? 32'h4e : 32'h2e);
    rdChk("opt24", GOPT24_IDX, {29'h0, s[0], s[1], 1'b0});
    rdChk("opt26", GOPT26_IDX, {25'h0, s[2], 6'h00});
    wr(GOPT26_IDX, {25'h0, ~s[2], 6'h00});
    settle(2);
    chk("cfgAddrSw", 32'(cfgPortAddr), s[2] ? 32'h2e : 32'h4e);
    rdChk("straps", STRAP_IDX, {25'h0, s[2], 3'h0, s[0], s[1], 1'b0});
  endtask

  task automatic tOutputs();
    logic [2:0] p;
    for (int i = 0; i < 2; i++) begin
      p = i ? 3'b010 : 3'b101;
      @(posedge clk);
      portASerialTx <= p[0];
      portATerminalReadyN <= p[1];
      portARequestSendN <= p[2];
      settle(2);
      chk("txPin", 32'(modemPinOut[PIN_TX]), 32'(p[0]));
      chk("dtrPin", 32'(modemPinOut[PIN_DTR]), 32'(p[1]));
      chk("rtsPin", 32'(modemPinOut[PIN_RTS]), 32'(p[2]));
      chk("drvOe", 32'(modemPinOe & SER_OUT_MASK), 32'h34);
    end
  endtask

  task automatic tInputs();
    logic [3:0] m;
    for (int i = 0; i < 2; i++) begin
      m = i ? 4'ha : 4'h5;
      @(posedge clk);
      modemCtl <= m;
      settle(8);
      chk("ring", 32'(portARingInN), 32'(m[0]));
      chk("carrier", 32'(portACarrierDetectN), 32'(m[1]));
      chk("rx", 32'(portASerialRx), 32'(m[2]));
      chk("setReady", 32'(portASetReadyN), 32'(m[3]));
      rdChk("status", PORT_STAT_IDX,
        {24'h0, 1'b1, ~m[3], 2'b00, m[2], 1'b0, ~m[1], ~m[0]});
    end
    @(posedge clk);
    modemCtl <= 4'hf;
  endtask

  task automatic tGpio();
    logic [31:0] q;
    logic e;
    @(posedge clk);
    pinFuncGpio <= 7'h7f;
    rdChk("dirRst", GPIO6_DIR_IDX, 32'h0);
    rdChk("dataRst", GPIO6_DATA_IDX, 32'h7f);
    wr(GPIO6_DIR_IDX, 32'h7f);
    wr(GPIO6_DATA_IDX, 32'h2a);
    settle(8);
    chk("gpioOe", 32'(modemPinOe), 32'h75);
    chk("gpioOut", 32'(modemPinOut), 32'h20);
    chk("ringMask", 32'(portARingInN), 32'h1);
    rdChk("pinLevel", GPIO6_PIN_IDX, 32'h2a);
    apb(1'b0, 8'hff, 32'h0, q, e);
    chk("unmapErr", 32'(e), 32'h1);
    chk("unmapData", q, 32'h0);
    @(posedge clk);
    pinFuncGpio <= 7'h00;
  endtask

  task automatic results();
    $display("Checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    ce = 1'b1;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pinFuncGpio = 7'h00;
    portASerialTx = 1'b1;
    portATerminalReadyN = 1'b1;
    portARequestSendN = 1'b1;
    strapVal = 3'b101;
    modemCtl = 4'hf;
    miscompares = 0;
    samples_checked = 0;
    tStraps(3'b101);
    tOutputs();
    tInputs();
    tGpio();
    tStraps(3'b010);
    results();
  end

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule
